// [adc_demux_consts.svh]
/*
  Constants for the converter output demultiplexer: code width, FIFO depth,
  pin synchroniser layout and reset values.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef ADC_DEMUX_CONSTS_SVH
`define ADC_DEMUX_CONSTS_SVH

`define ADC_CODE_W 8
`define ADC_FIFO_DEPTH 8
`define ADC_SYNC_W 4
`define ADC_PIN_RST_TTL 0
`define ADC_PIN_RST_DIFF 1
`define ADC_PIN_POL 2
`define ADC_PIN_MODE 3
`define ADC_SYNC_RESET 4'hf
`define ADC_CODE_RESET 8'h00

`endif

// [adc_demux_pkg.sv]
/*
  Types shared by the output demultiplexer.
  Assumes adc_demux_consts.svh is on the include path.
*/
`include "adc_demux_consts.svh"

package adc_demux_pkg;

  typedef struct packed {
    logic [`ADC_SYNC_W-1:0] pin_meta;
    logic [`ADC_SYNC_W-1:0] pin_sync;
    logic half_phase;
    logic [`ADC_CODE_W-1:0] held_code;
    logic [`ADC_CODE_W-1:0] first_code;
    logic [`ADC_CODE_W-1:0] second_code;
    logic word_valid;
  } demux_state_t;

endpackage : adc_demux_pkg

// [capture_sink.sv]
/*
  Downstream capture model: accepts a word pair whenever the ports report
  an update, stalls on request.
  Assumes the demultiplexer's clock and that word_valid is a one-cycle pulse.
*/
`timescale 1ns/10ps
`default_nettype none

module capture_sink (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic stall_in,
  input wire logic word_valid_in,
  input wire logic [7:0] first_in,
  input wire logic [7:0] second_in,
  input wire logic [5:0] pick_in,
  output logic ready_out,
  output logic [15:0] picked_out,
  output var int count_out
);
  // Last 64 captured pairs in arrival order, read back by index
  logic [15:0] words [0:63];

  assign ready_out = !stall_in;
  assign picked_out = words[pick_in];

  always @(posedge ref_clk_in or negedge arst_n_in)
    if (!arst_n_in)
      count_out <= 0;
    else if (word_valid_in === 1'b1)
    begin
      words[count_out[5:0]] <= {second_in, first_in};
      count_out <= count_out + 1;
    end
endmodule : capture_sink

`default_nettype wire

// [flash_adc_output_demux.sv]
/*
  Digital output side of an 8-bit flash converter: polarity coding, straight
  and two-port half-rate output modes, resettable divide-by-two phase.
  Assumes sample words arrive on ref_clk_in, one per sample clock, and that
  the static pins (resets, polarity, mode) are asynchronous to it. A pin's
  _conn_in input is low when that pin is left open.
*/
// Functional notes
// R1: Low reset input clears the divide-by-two divider
// R2: Open TTL reset input reads as high
// R3: Open polarity input reads as high
// R4: Polarity high straight binary, low complemented code
// R5: Mode high: divide by two, demultiplex samples
// R6: Half-rate mode: two ports at half rate
// R7: Half-rate mode: divided clock on strobe output
// R8: Straight mode: inverted sample clock on strobe
// R9: Straight mode: one word per clock period
// R10: Two independent 8-bit output ports
// R11: Controller pulses reset to align parallel converters
// R12: Samples alternate ports, both update together
`timescale 1ns/10ps
`default_nettype none

`include "adc_demux_consts.svh"

module flash_adc_output_demux #(
  parameter int CODE_W = `ADC_CODE_W,
  parameter int FIFO_DEPTH = `ADC_FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [CODE_W-1:0] sample_code_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  input wire logic divider_reset_n_ttl_in,
  input wire logic divider_reset_n_ttl_conn_in,
  input wire logic divider_reset_n_diff_in,
  input wire logic code_polarity_pin_in,
  input wire logic code_polarity_conn_in,
  input wire logic two_port_half_rate_mode_in,
  input wire logic capture_ready_in,
  output logic [CODE_W-1:0] first_port_code_out,
  output logic [CODE_W-1:0] second_port_code_out,
  output logic word_valid_out,
  output logic output_strobe_out
);

  adc_demux_pkg::demux_state_t st;
  adc_demux_pkg::demux_state_t next_st;
  logic [`ADC_SYNC_W-1:0] pin_raw;
  logic fifo_valid;
  logic [CODE_W-1:0] fifo_data;
  logic [CODE_W-1:0] code;
  logic div_rst;
  logic mode;
  logic pol;
  logic pop;

  // Open pins resolve to their pulled-up level before synchronising
  assign pin_raw[`ADC_PIN_RST_TTL] = divider_reset_n_ttl_conn_in ? divider_reset_n_ttl_in
                                                                 : 1'b1; // [R2]
  assign pin_raw[`ADC_PIN_RST_DIFF] = divider_reset_n_diff_in;
  assign pin_raw[`ADC_PIN_POL] = code_polarity_conn_in ? code_polarity_pin_in : 1'b1; // [R3]
  assign pin_raw[`ADC_PIN_MODE] = two_port_half_rate_mode_in;

  assign div_rst = ~(st.pin_sync[`ADC_PIN_RST_TTL] & st.pin_sync[`ADC_PIN_RST_DIFF]); // [R1]
  assign mode = st.pin_sync[`ADC_PIN_MODE];
  assign pol = st.pin_sync[`ADC_PIN_POL];
  assign code = pol ? fifo_data : ~fifo_data; // [R4]
  // No FIFO sample is popped while the divider is in reset in half-rate mode
  assign pop = fifo_valid & capture_ready_in & ~(mode & div_rst);

  sample_fifo #(
    .WIDTH(CODE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(sample_valid_in),
    .in_ready_out(sample_ready_out),
    .in_data_in(sample_code_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(pop),
    .out_data_out(fifo_data)
  );

  always_comb
  begin
    next_st = st;
    next_st.pin_meta = pin_raw;
    next_st.pin_sync = st.pin_meta;
    next_st.word_valid = 1'b0;
    if (mode)
    begin
      if (div_rst)
      begin
        next_st.half_phase = 1'b0; // [R1] [R11]
      end
      else if (pop)
      begin
        if (!st.half_phase)
        begin
          next_st.held_code = code; // [R5] [R12]
          next_st.half_phase = 1'b1;
        end
        else
        begin
          next_st.first_code = st.held_code; // [R6] [R10] [R12]
          next_st.second_code = code;
          next_st.half_phase = 1'b0;
          next_st.word_valid = 1'b1;
        end
      end
    end
    else
    begin
      next_st.half_phase = 1'b0;
      if (pop)
      begin
        next_st.first_code = code; // [R9]
        next_st.word_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st.pin_meta <= `ADC_SYNC_RESET;
      st.pin_sync <= `ADC_SYNC_RESET;
      st.half_phase <= 1'b0;
      st.held_code <= `ADC_CODE_RESET;
      st.first_code <= `ADC_CODE_RESET;
      st.second_code <= `ADC_CODE_RESET;
      st.word_valid <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign first_port_code_out = st.first_code;
  assign second_port_code_out = st.second_code;
  assign word_valid_out = st.word_valid;
  // Divided phase rises mid-pair, giving margin around the data update
  assign output_strobe_out = mode ? st.half_phase : ~ref_clk_in; // [R7] [R8]

  AST_RESET_PHASE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R1]
    (mode && div_rst) |=> !st.half_phase)
    else $error("divider phase not cleared by reset");

  AST_TTL_OPEN: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R2]
    (!divider_reset_n_ttl_conn_in && divider_reset_n_diff_in)[*3] |=> !div_rst)
    else $error("open reset input held the divider in reset");

  AST_POL_OPEN: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R3]
    (!code_polarity_conn_in)[*3] |=> pol)
    else $error("open polarity input did not read high");

  AST_CODE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R4]
    (!mode && pop) |=> first_port_code_out == ($past(pol) ? $past(fifo_data)
                                                          : ~$past(fifo_data)))
    else $error("output code polarity wrong");

  AST_HALF_RATE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R6]
    (mode && $past(mode) && word_valid_out) |=> !word_valid_out)
    else $error("two-port words faster than half rate");

  AST_STROBE_LOW: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R7]
    (mode && word_valid_out) |-> !output_strobe_out ##1 1'b1)
    else $error("strobe high when pair updates");

  AST_STRAIGHT: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R9]
    (!mode && pop) |=> word_valid_out)
    else $error("straight mode word not issued");

  AST_PAIR: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R12]
    (mode && st.half_phase && pop) |=>
      (second_port_code_out == $past(code)) && (first_port_code_out == $past(st.held_code)))
    else $error("pair not presented together");

  AST_PORTS_HOLD: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R10]
    !$stable(first_port_code_out) |-> word_valid_out)
    else $error("port changed without a word");

  AST_DIFF_RESET: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R1]
    (!divider_reset_n_diff_in)[*3] |=> div_rst)
    else $error("differential reset input not seen");

  AST_SECOND_HOLD: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R9]
    (!mode && !$past(mode)) |-> $stable(second_port_code_out))
    else $error("second port changed in straight mode");

  AST_PAIR_ALTERNATE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R12]
    (mode && pop && !st.half_phase) |=> (st.half_phase && !word_valid_out))
    else $error("first sample of a pair not held back");

  COV_PAIR: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    mode && word_valid_out);
  COV_STRAIGHT: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !mode && word_valid_out ##1 word_valid_out);
  COV_DIV_RST: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    mode && st.half_phase && div_rst);
  COV_FULL: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !sample_ready_out);
  COV_POL_INV: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !pol && word_valid_out);

endmodule : flash_adc_output_demux

`default_nettype wire

// [sample_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides, width and depth set by
  parameters. Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none

`include "adc_demux_consts.svh"

module sample_fifo #(
  parameter int WIDTH = `ADC_CODE_W,
  parameter int DEPTH = `ADC_FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic push;
  logic pop;

  assign in_ready_out = (st.count != FULL);
  assign out_valid_out = (st.count != '0);
  assign out_data_out = st.mem[st.rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wr_ptr] = in_data_in;
      next_st.wr_ptr = (st.wr_ptr == LAST) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_st.rd_ptr = (st.rd_ptr == LAST) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_st.count = st.count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule : sample_fifo

`default_nettype wire

// [tb.sv]
/*
  Self-checking bench for the converter output demultiplexer.
  Assumes adc_demux_consts.svh on the include path and capture_sink.
*/
`timescale 1ns/10ps
`default_nettype none

`include "adc_demux_consts.svh"

module tb;
  logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, rdy, rst_ttl_n = 1'b1, ttl_conn = 1'b1;
  logic rst_diff_n = 1'b1;
  logic pol = 1'b1, pol_conn = 1'b0, mode = 1'b0, cap_rdy, wv, strobe, stall = 1'b0;
  logic [7:0] code = 8'h00, p1, p2;
  logic [15:0] picked;
  int cnt, errors = 0, n_compared = 0, i, n_got = 0;

  always #50 clk = ~clk;

  flash_adc_output_demux i_flash_adc_output_demux (.ref_clk_in(clk), .arst_n_in(rst_n),
    .sample_code_in(code), .sample_valid_in(valid), .sample_ready_out(rdy),
    .divider_reset_n_ttl_in(rst_ttl_n), .divider_reset_n_ttl_conn_in(ttl_conn),
    .divider_reset_n_diff_in(rst_diff_n), .code_polarity_pin_in(pol),
    .code_polarity_conn_in(pol_conn), .two_port_half_rate_mode_in(mode),
    .capture_ready_in(cap_rdy), .first_port_code_out(p1), .second_port_code_out(p2),
    .word_valid_out(wv), .output_strobe_out(strobe));
  capture_sink i_capture_sink (.ref_clk_in(clk), .arst_n_in(rst_n), .stall_in(stall),
    .word_valid_in(wv), .first_in(p1), .second_in(p2), .pick_in(6'(n_got)),
    .ready_out(cap_rdy), .picked_out(picked), .count_out(cnt));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic put(input logic [7:0] d);
    code = d;
    valid = 1'b1;
    for (int k = 0; k < 50 && rdy !== 1'b1; k++) @(posedge clk);
    @(posedge clk);
    #1;
  endtask : put

  task automatic idle(input int n);
    valid = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic get(input logic [15:0] e);
    for (int k = 0; k < 20 && cnt <= n_got; k++)
    begin
      @(posedge clk);
      #1;
    end
    chk(16'(cnt > n_got), 16'h0001);
    chk(picked, e);
    n_got++;
  endtask : get

  task automatic t_straight;
    put(8'h3c);
    idle(1);
    get(16'h003c);
    chk(strobe, 1'b0);
    #50 chk(strobe, 1'b1);
    @(posedge clk);
    #1 pol_conn = 1'b1;
    pol = 1'b0;
    idle(3);
    put(8'h3c);
    put(8'hff);
    idle(1);
    get(16'h00c3);
    get(16'h0000);
    pol_conn = 1'b0;
    chk(16'(cnt), 16'(n_got));
  endtask : t_straight

  task automatic t_pair;
    mode = 1'b1;
    idle(3);
    put(8'ha1);
    put(8'hb2);
    idle(1);
    get(16'hb2a1);
    chk(strobe, 1'b0);
    put(8'hc3);
    idle(3);
    chk(strobe, 1'b1);
    rst_ttl_n = 1'b0;
    idle(4);
    chk(strobe, 1'b0);
    rst_ttl_n = 1'b1;
    idle(3);
    put(8'hd4);
    put(8'he5);
    idle(1);
    get(16'he5d4);
    put(8'h38);
    idle(3);
    chk(strobe, 1'b1);
    rst_diff_n = 1'b0;
    idle(4);
    chk(strobe, 1'b0);
    rst_diff_n = 1'b1;
    idle(3);
    ttl_conn = 1'b0;
    rst_ttl_n = 1'b0;
    idle(3);
    put(8'h16);
    idle(4);
    chk(strobe, 1'b1);
    put(8'h27);
    idle(1);
    get(16'h2716);
    ttl_conn = 1'b1;
    rst_ttl_n = 1'b1;
    chk(16'(cnt), 16'(n_got));
  endtask : t_pair

  task automatic t_fifo;
    stall = 1'b1;
    for (i = 0; i < 8; i++) put(8'(8'h10 + i));
    idle(1);
    chk(rdy, 1'b0);
    stall = 1'b0;
    for (i = 0; i < 4; i++) get({8'(8'h11 + 2 * i), 8'(8'h10 + 2 * i)});
    chk(rdy, 1'b1);
    chk(16'(cnt), 16'(n_got));
  endtask : t_fifo

  task automatic report_and_stop;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #2000000;
    errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    idle(3);
    t_straight();
    t_pair();
    t_fifo();
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
